/* File: umh_regs.vh */
`ifndef UMH_REGS_VH
`define UMH_REGS_VH

// register byte offsets
`define UMH_MCR_PRI_OFS      8'h00
`define UMH_IER_PRI_OFS      8'h04
`define UMH_MSR_PRI_OFS      8'h08
`define UMH_MCR_SEC_OFS      8'h10
`define UMH_IER_SEC_OFS      8'h14
`define UMH_MSR_SEC_OFS      8'h18
`define UMH_CFG_OFS          8'h20
`define UMH_STAT_OFS         8'h24

// modem control fields
`define UMH_MCR_DTR          0
`define UMH_MCR_RTS          1
`define UMH_MCR_OUT1         2
`define UMH_MCR_OUT2         3
`define UMH_MCR_LOOP         4
`define UMH_MCR_W            5

// interrupt enable: modem status change
`define UMH_IER_MS           3

// modem status fields
`define UMH_MSR_DCTS         0
`define UMH_MSR_DDSR         1
`define UMH_MSR_TERI         2
`define UMH_MSR_DDCD         3
`define UMH_MSR_CTS          4
`define UMH_MSR_DSR          5
`define UMH_MSR_RI           6
`define UMH_MSR_DCD          7

// configuration fields and reset value
`define UMH_CFG_ADAPTER      0
`define UMH_CFG_PRI_LSB      1
`define UMH_CFG_SEC_LSB      3
`define UMH_CFG_W            5
`define UMH_CFG_RST          5'h08

// com slot codes: 0..3 = first..fourth slot
`define UMH_COM_W            2

// bus constants
`define UMH_HTRANS_NONSEQ    2'b10
`define UMH_ADDR_W           8

// reset pulse the system must give, and its cycle count at 250 MHz
`define UMH_RST_MIN_NS       500
`define UMH_CLK_NS           4
`define UMH_RST_MIN_CYC      ((`UMH_RST_MIN_NS + `UMH_CLK_NS - 1) / `UMH_CLK_NS)

`endif

/* File: umh_port.v */
`include "umh_regs.vh"

module umh_port (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       hw_rst,
  // modem pins, asynchronous
  input  wire       cts_pin_n,
  input  wire       dsr_pin_n,
  input  wire       dcd_pin_n,
  input  wire       ri_pin_n,
  // control
  input  wire [4:0] modem_control_reg,
  input  wire       ier_ms,
  input  wire       msr_rd,
  // status
  output wire [7:0] modem_status_reg,
  output wire       irq
);

  reg  [3:0] meta_ff;
  reg  [3:0] sync_ff;
  reg  [3:0] prev_ff;
  reg  [3:0] delta_ff;
  reg        pend_ff;
  wire [3:0] lvl_n;
  wire [3:0] rise_n;
  wire       chg;

  // order: cts, dsr, ri, dcd matches delta bits 0..3
  // loopback feeds the control bits back, inverted like a pin
  assign lvl_n  = modem_control_reg[`UMH_MCR_LOOP] ?
                  ~{modem_control_reg[`UMH_MCR_OUT2], modem_control_reg[`UMH_MCR_OUT1],
                    modem_control_reg[`UMH_MCR_DTR], modem_control_reg[`UMH_MCR_RTS]} : sync_ff;
  assign rise_n = lvl_n & ~prev_ff;
  assign chg    = |(lvl_n ^ prev_ff);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff  <= 4'hf;
      sync_ff  <= 4'hf;
      prev_ff  <= 4'hf;
      delta_ff <= 4'h0;
      pend_ff  <= 1'b0;
    end else if (ce) begin
      meta_ff <= {dcd_pin_n, ri_pin_n, dsr_pin_n, cts_pin_n};
      sync_ff <= meta_ff;
      prev_ff <= lvl_n;
      if (hw_rst) begin
        delta_ff <= 4'h0;
        pend_ff  <= 1'b0;
      end else begin
        // a new edge beats the read that clears
        delta_ff <= (delta_ff & {4{~msr_rd}}) | rise_n; // RULE7 RULE9 RULE11 RULE19 RULE21
        pend_ff  <= (pend_ff & ~msr_rd) | chg; // RULE12 RULE21
      end
    end
  end

  assign modem_status_reg = {~lvl_n[3], ~lvl_n[2], ~lvl_n[1], ~lvl_n[0], delta_ff}; // RULE6 RULE8 RULE10 RULE18
  assign irq = pend_ff & ier_ms; // RULE12

endmodule // umh_port

/* File: umh_modem_handshake.v */
// Behaviour
// RULE1 - send-request pin low when control bit 1 is set
// RULE2 - terminal-ready pin low when control bit 0 is set
// RULE3 - hardware reset drives send-request pin high
// RULE4 - hardware reset drives terminal-ready pin high
// RULE5 - loopback holds send-request and terminal-ready pins high
// RULE6 - status bit 4 reads inverse of clear-to-send pin
// RULE7 - clear-to-send pin rising since last status read sets status bit 0
// RULE8 - status bit 5 reads inverse of set-ready pin
// RULE9 - set-ready pin rising since last status read sets status bit 1
// RULE10 - status bit 7 reads inverse of carrier-detect pin
// RULE11 - carrier-detect pin rising since last status read sets status bit 3
// RULE12 - with enable bit 3, any cts, dsr or dcd change raises interrupt
// RULE13 - transmit output never gated by clear-to-send
// RULE14 - system holds hardware reset at least 500 ns
// RULE15 - hardware reset keeps configuration, clears other state
// RULE16 - adapter variant latches straps on falling edge of hardware reset
// RULE17 - adapter variant straps, sampled during reset, pick secondary address
// RULE18 - status bit 6 reads inverse of ring pin
// RULE19 - ring pin rising since last status read sets status bit 2
// RULE20 - motherboard: first and third slots on irq4, second and fourth on irq3
// RULE21 - status read clears change flags and the status interrupt
`include "umh_regs.vh"

module umh_modem_handshake (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // hardware reset pin, active high, asynchronous
  input  wire        hw_reset,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // primary modem pins
  input  wire        clear_to_send_pri_n,
  input  wire        set_ready_pri_n,
  input  wire        carrier_detect_pri_n,
  input  wire        ring_indicator_pri_n,
  output reg         send_request_pri_n,
  output reg         terminal_ready_pri_n,
  // secondary modem pins
  input  wire        clear_to_send_sec_n,
  input  wire        set_ready_sec_n,
  input  wire        carrier_detect_sec_n,
  input  wire        ring_indicator_sec_n,
  output reg         send_request_sec_n,
  output reg         terminal_ready_sec_n,
  // transmit bits from the uart cores, same clock
  input  wire        tx_bit_pri,
  input  wire        tx_bit_sec,
  output reg         serial_out_pri,
  output reg         serial_out_sec,
  // adapter straps, asynchronous
  input  wire        sec_port_strap_0,
  input  wire        sec_port_strap_1,
  // interrupt lines
  output reg         irq4,
  output reg         irq3,
  output reg         port_irq_pri,
  output reg         port_irq_sec,
  // effective secondary slot
  output reg  [1:0]  sec_addr_sel
);

  // hardware reset and strap synchronisers
  reg        rst_meta_ff;
  reg        rst_sync_ff;
  reg        rst_prev_ff;
  reg  [1:0] strap_meta_ff;
  reg  [1:0] strap_sync_ff;
  reg  [1:0] strap_hold_ff;
  reg  [1:0] strap_lat_ff;
  wire       hw_rst;
  wire       rst_fall;

  // registers
  reg  [`UMH_MCR_W-1:0] mcr_pri_ff;
  reg  [`UMH_MCR_W-1:0] mcr_sec_ff;
  reg                   ier_pri_ff;
  reg                   ier_sec_ff;
  reg  [`UMH_CFG_W-1:0] cfg_ff;

  // bus data phase
  reg                   wr_pend_ff;
  reg  [`UMH_ADDR_W-1:0] wr_addr_ff;
  reg  [31:0]           nxt_hrdata;
  wire                  acc;
  wire                  rd_acc;
  wire [`UMH_ADDR_W-1:0] a_ofs;
  wire                  msr_rd_pri;
  wire                  msr_rd_sec;

  // port status
  wire [7:0]            msr_pri;
  wire [7:0]            msr_sec;
  wire                  irq_pri;
  wire                  irq_sec;

  // irq routing
  wire [1:0]            pri_sel;
  wire [1:0]            sec_sel;
  wire                  adapter;
  reg                   nxt_irq4;
  reg                   nxt_irq3;

  assign hw_rst   = rst_sync_ff;
  assign rst_fall = rst_prev_ff & ~rst_sync_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_ff   <= 1'b0;
      rst_prev_ff   <= 1'b0;
      strap_meta_ff <= 2'h0;
      strap_sync_ff <= 2'h0;
      strap_hold_ff <= 2'h0;
      strap_lat_ff  <= 2'h0;
    end else if (ce) begin
      rst_meta_ff   <= hw_reset;
      rst_sync_ff   <= rst_meta_ff;
      rst_prev_ff   <= rst_sync_ff;
      strap_meta_ff <= {sec_port_strap_1, sec_port_strap_0};
      strap_sync_ff <= strap_meta_ff;
      // track straps only while reset is asserted
      if (rst_sync_ff) begin
        strap_hold_ff <= strap_sync_ff; // RULE17
      end
      // keep the value seen just before the release
      if (rst_fall) begin
        strap_lat_ff <= strap_hold_ff; // RULE16
      end
    end
  end

  // ahb-lite: zero wait states, read data registered at address phase
  assign acc    = hsel & hready & htrans[1];
  assign rd_acc = acc & ~hwrite;
  assign a_ofs  = haddr[`UMH_ADDR_W-1:0];

  // reading status both returns and clears the change flags
  assign msr_rd_pri = rd_acc & (a_ofs == `UMH_MSR_PRI_OFS); // RULE21
  assign msr_rd_sec = rd_acc & (a_ofs == `UMH_MSR_SEC_OFS); // RULE21

  always @* begin
    nxt_hrdata = 32'h0000_0000;
    case (a_ofs)
      `UMH_MCR_PRI_OFS: begin
        nxt_hrdata[`UMH_MCR_W-1:0] = mcr_pri_ff;
      end
      `UMH_IER_PRI_OFS: begin
        nxt_hrdata[`UMH_IER_MS] = ier_pri_ff;
      end
      `UMH_MSR_PRI_OFS: begin
        nxt_hrdata[7:0] = msr_pri;
      end
      `UMH_MCR_SEC_OFS: begin
        nxt_hrdata[`UMH_MCR_W-1:0] = mcr_sec_ff;
      end
      `UMH_IER_SEC_OFS: begin
        nxt_hrdata[`UMH_IER_MS] = ier_sec_ff;
      end
      `UMH_MSR_SEC_OFS: begin
        nxt_hrdata[7:0] = msr_sec;
      end
      `UMH_CFG_OFS: begin
        nxt_hrdata[`UMH_CFG_W-1:0] = cfg_ff;
      end
      `UMH_STAT_OFS: begin
        nxt_hrdata[7:0] = {irq_sec, irq_pri, port_irq_sec, port_irq_pri,
                           irq3, irq4, strap_lat_ff};
      end
      default: begin
        nxt_hrdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (ce) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (hready) begin
        wr_pend_ff <= acc & hwrite;
        wr_addr_ff <= a_ofs;
        hrdata     <= rd_acc ? nxt_hrdata : 32'h0000_0000;
      end
    end
  end

  // control registers; cfg survives the hardware reset pin
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcr_pri_ff <= 5'h00;
      mcr_sec_ff <= 5'h00;
      ier_pri_ff <= 1'b0;
      ier_sec_ff <= 1'b0;
      cfg_ff     <= `UMH_CFG_RST;
    end else if (ce) begin
      if (hw_rst) begin
        mcr_pri_ff <= 5'h00; // RULE15
        mcr_sec_ff <= 5'h00;
        ier_pri_ff <= 1'b0;
        ier_sec_ff <= 1'b0;
      end else if (wr_pend_ff) begin
        case (wr_addr_ff)
          `UMH_MCR_PRI_OFS: begin
            mcr_pri_ff <= hwdata[`UMH_MCR_W-1:0];
          end
          `UMH_IER_PRI_OFS: begin
            ier_pri_ff <= hwdata[`UMH_IER_MS];
          end
          `UMH_MCR_SEC_OFS: begin
            mcr_sec_ff <= hwdata[`UMH_MCR_W-1:0];
          end
          `UMH_IER_SEC_OFS: begin
            ier_sec_ff <= hwdata[`UMH_IER_MS];
          end
          default: begin
            mcr_pri_ff <= mcr_pri_ff;
          end
        endcase
      end
      // configuration is written regardless of the reset pin
      if (wr_pend_ff && wr_addr_ff == `UMH_CFG_OFS) begin
        cfg_ff <= hwdata[`UMH_CFG_W-1:0]; // RULE15
      end
    end
  end

  umh_port u_port_pri (
    .clk       (hclk),
    .rst_n     (hresetn),
    .ce        (ce),
    .hw_rst    (hw_rst),
    .cts_pin_n (clear_to_send_pri_n),
    .dsr_pin_n (set_ready_pri_n),
    .dcd_pin_n (carrier_detect_pri_n),
    .ri_pin_n  (ring_indicator_pri_n),
    .modem_control_reg       (mcr_pri_ff),
    .ier_ms    (ier_pri_ff),
    .msr_rd    (msr_rd_pri),
    .modem_status_reg       (msr_pri),
    .irq       (irq_pri)
  );

  umh_port u_port_sec (
    .clk       (hclk),
    .rst_n     (hresetn),
    .ce        (ce),
    .hw_rst    (hw_rst),
    .cts_pin_n (clear_to_send_sec_n),
    .dsr_pin_n (set_ready_sec_n),
    .dcd_pin_n (carrier_detect_sec_n),
    .ri_pin_n  (ring_indicator_sec_n),
    .modem_control_reg       (mcr_sec_ff),
    .ier_ms    (ier_sec_ff),
    .msr_rd    (msr_rd_sec),
    .modem_status_reg       (msr_sec),
    .irq       (irq_sec)
  );

  // slot selection; adapter takes the secondary slot from straps
  assign adapter = cfg_ff[`UMH_CFG_ADAPTER];
  assign pri_sel = cfg_ff[`UMH_CFG_PRI_LSB +: `UMH_COM_W];
  assign sec_sel = adapter ? strap_lat_ff :
                   cfg_ff[`UMH_CFG_SEC_LSB +: `UMH_COM_W]; // RULE17

  // motherboard only: slots 0 and 2 share irq4, 1 and 3 share irq3: low select bit decides; adapter holds both low
  always @* begin
    nxt_irq4 = 1'b0;
    nxt_irq3 = 1'b0;
    if (!adapter) begin
      nxt_irq4 = (irq_pri & ~pri_sel[0]) | (irq_sec & ~sec_sel[0]); // RULE20
      nxt_irq3 = (irq_pri & pri_sel[0]) | (irq_sec & sec_sel[0]); // RULE20
    end
  end

  // pin outputs, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_request_pri_n   <= 1'b1;
      terminal_ready_pri_n <= 1'b1;
      send_request_sec_n   <= 1'b1;
      terminal_ready_sec_n <= 1'b1;
      serial_out_pri       <= 1'b1;
      serial_out_sec       <= 1'b1;
      irq4                 <= 1'b0;
      irq3                 <= 1'b0;
      port_irq_pri         <= 1'b0;
      port_irq_sec         <= 1'b0;
      sec_addr_sel         <= 2'h0;
    end else if (ce) begin
      if (hw_rst) begin
        send_request_pri_n   <= 1'b1; // RULE3
        terminal_ready_pri_n <= 1'b1; // RULE4
        send_request_sec_n   <= 1'b1; // RULE3
        terminal_ready_sec_n <= 1'b1; // RULE4
      end else begin
        send_request_pri_n   <= mcr_pri_ff[`UMH_MCR_LOOP] |
                                ~mcr_pri_ff[`UMH_MCR_RTS]; // RULE1 RULE5
        terminal_ready_pri_n <= mcr_pri_ff[`UMH_MCR_LOOP] |
                                ~mcr_pri_ff[`UMH_MCR_DTR]; // RULE2 RULE5
        send_request_sec_n   <= mcr_sec_ff[`UMH_MCR_LOOP] |
                                ~mcr_sec_ff[`UMH_MCR_RTS]; // RULE1 RULE5
        terminal_ready_sec_n <= mcr_sec_ff[`UMH_MCR_LOOP] |
                                ~mcr_sec_ff[`UMH_MCR_DTR]; // RULE2 RULE5
      end
      // no handshake gating: software owns flow control
      serial_out_pri <= tx_bit_pri | mcr_pri_ff[`UMH_MCR_LOOP]; // RULE13
      serial_out_sec <= tx_bit_sec | mcr_sec_ff[`UMH_MCR_LOOP]; // RULE13
      irq4           <= nxt_irq4;
      irq3           <= nxt_irq3;
      port_irq_pri   <= adapter & irq_pri;
      port_irq_sec   <= adapter & irq_sec;
      sec_addr_sel   <= sec_sel;
    end
  end

endmodule // umh_modem_handshake

/* File: umh_hs_props.sv */
`include "umh_regs.vh"

module umh_hs_props (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hw_reset,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // modem pins
  input wire logic        clear_to_send_pri_n,
  input wire logic        set_ready_pri_n,
  input wire logic        carrier_detect_pri_n,
  input wire logic        ring_indicator_pri_n,
  input wire logic        send_request_pri_n,
  input wire logic        terminal_ready_pri_n,
  input wire logic        send_request_sec_n,
  input wire logic        terminal_ready_sec_n,
  // transmit and straps
  input wire logic        tx_bit_pri,
  input wire logic        serial_out_pri,
  input wire logic        sec_port_strap_0,
  input wire logic        sec_port_strap_1,
  input wire logic [1:0]  sec_addr_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wa_ff;
  logic [4:0] mp_ff;
  logic       chk_ff;
  logic       ad_ff;
  logic [3:0] pv_ff;
  logic [3:0] sc_ff;
  wire        tk = hsel && hready && htrans[1];
  wire  [3:0] pv = {carrier_detect_pri_n, ring_indicator_pri_n, set_ready_pri_n, clear_to_send_pri_n};
  // mirror misses hw_reset clearing, so loop-gated checks only weaken after it
  wire        rd_p = tk && !hwrite && haddr[7:0] == `UMH_MSR_PRI_OFS && !mp_ff[4];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_ff <= 8'hff;
      mp_ff <= 5'h00;
      chk_ff <= 1'b0;
      ad_ff <= 1'b0;
      pv_ff <= 4'hf;
      sc_ff <= 4'h0;
    end else begin
      wa_ff <= (tk && hwrite) ? haddr[7:0] : 8'hff;
      chk_ff <= wa_ff == `UMH_MCR_PRI_OFS;
      if (wa_ff == `UMH_MCR_PRI_OFS) mp_ff <= hwdata[4:0];
      if (wa_ff == `UMH_CFG_OFS) ad_ff <= hwdata[0];
      pv_ff <= pv;
      // pins quiet count: flags settle three edges after a change
      sc_ff <= (pv != pv_ff) ? 4'h0 : (sc_ff == 4'hf) ? sc_ff : sc_ff + 4'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  send_req_pri_a: assert property (chk_ff && !hw_reset |=>
    send_request_pri_n == !(mp_ff[1] && !mp_ff[4])) else $error("send request pin wrong");
  term_rdy_pri_a: assert property (chk_ff && !hw_reset |=>
    terminal_ready_pri_n == !(mp_ff[0] && !mp_ff[4])) else $error("terminal ready pin wrong");
  hw_rst_pins_a: assert property (hw_reset [*4] |-> send_request_pri_n &&
    terminal_ready_pri_n && send_request_sec_n && terminal_ready_sec_n) else $error("pins low in reset");
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  msr_level_a: assert property (rd_p && sc_ff >= 4'h4 && !hw_reset |=>
    hrdata[7:4] == ~$past(pv)) else $error("status levels wrong");
  msr_clear_a: assert property ((rd_p && sc_ff >= 4'h4) ##2 (rd_p && sc_ff >= 4'h6) |=>
    hrdata[3:0] == 4'h0) else $error("change flags not cleared");
  tx_path_a: assert property (!mp_ff[4] |=>
    serial_out_pri == $past(tx_bit_pri)) else $error("transmit output gated");
  strap_latch_a: assert property (ad_ff && $fell(hw_reset) |-> ##6
    sec_addr_sel == {sec_port_strap_1, sec_port_strap_0}) else $error("strap slot wrong");

  cover property (rd_p);
  cover property (chk_ff && mp_ff[4]);
  cover property (ad_ff && $fell(hw_reset));
endmodule // umh_hs_props

bind umh_modem_handshake umh_hs_props u_props (.*);

/* File: umh_modem_sim.sv */
module umh_modem_sim (
  // clock
  input  wire logic       hclk,
  // pacing and wanted levels {sec dcd ri dsr cts, pri dcd ri dsr cts}
  input  wire logic       slow,
  input  wire logic [7:0] want,
  // modem lines, active low
  output logic      [7:0] lines_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pend_ff = 8'hff;
  logic [3:0] cnt_ff = 4'h0;

  initial lines_n = 8'hff;
  // a slow modem settles its lines several cycles after deciding
  always @(posedge hclk) begin
    if (want != pend_ff) begin
      pend_ff <= want;
      cnt_ff <= slow ? 4'h5 : 4'h0;
    end else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    else lines_n <= pend_ff;
  end
endmodule // umh_modem_sim

/* File: tb_top.sv */
`include "umh_regs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, ce, hw_reset, hsel, hwrite, hready, slow;
  logic        tx_bit_pri, tx_bit_sec, sec_port_strap_0, sec_port_strap_1;
  logic [1:0]  htrans, sec_addr_sel;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0]  want, lines_n;
  logic        hreadyout, hresp, serial_out_pri, serial_out_sec;
  logic        irq4, irq3, port_irq_pri, port_irq_sec;
  logic        send_request_pri_n, terminal_ready_pri_n, send_request_sec_n, terminal_ready_sec_n;
  logic        clear_to_send_pri_n, set_ready_pri_n, carrier_detect_pri_n, ring_indicator_pri_n;
  logic        clear_to_send_sec_n, set_ready_sec_n, carrier_detect_sec_n, ring_indicator_sec_n;
  int          n_errors = 0;
  int          n_checks = 0;
  wire  [3:0]  pins = {send_request_pri_n, terminal_ready_pri_n, send_request_sec_n,
                       terminal_ready_sec_n};

  assign hready = hreadyout;
  assign {carrier_detect_sec_n, ring_indicator_sec_n, set_ready_sec_n, clear_to_send_sec_n,
          carrier_detect_pri_n, ring_indicator_pri_n, set_ready_pri_n, clear_to_send_pri_n} = lines_n;

  umh_modem_handshake uut (.*);
  umh_modem_sim mdm (.hclk(hclk), .slow(slow), .want(want), .lines_n(lines_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= `UMH_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    $display("watchdog expired");
    wrap_up;
  end

  initial begin
    {hresetn, ce, hw_reset, hsel, hwrite, slow} = 6'b010000;
    {htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {tx_bit_pri, tx_bit_sec} = 2'b11;
    {sec_port_strap_1, sec_port_strap_0} = 2'h2;
    want = 8'hff;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({28'h0, pins}, 32'hf);
    rd(`UMH_CFG_OFS, 32'h8);
    rd(8'h30, 32'h0);
    rd(`UMH_MCR_PRI_OFS, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(`UMH_MCR_PRI_OFS, 32'(i));
      wr(`UMH_MCR_SEC_OFS, 32'(3 - i));
      repeat (2) @(posedge hclk);
      chk({28'h0, pins}, {28'h0, ~i[1:0], i[1:0]});
    end
    wr(`UMH_MCR_PRI_OFS, 32'h13);
    wr(`UMH_MCR_SEC_OFS, 32'h13);
    repeat (2) @(posedge hclk);
    chk({28'h0, pins}, 32'hf);
    wr(`UMH_MCR_PRI_OFS, 32'h0);
    wr(`UMH_MCR_SEC_OFS, 32'h0);
    $display("test control done");
    want <= 8'hf0;
    repeat (14) @(posedge hclk);
    ahb(1'b0, `UMH_MSR_PRI_OFS, 32'h0, q);
    rd(`UMH_MSR_PRI_OFS, 32'hf0);
    ahb(1'b0, `UMH_MSR_SEC_OFS, 32'h0, q);
    rd(`UMH_MSR_SEC_OFS, 32'h0);
    // one line at a time, alternating prompt and slow modem
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      want[k] <= 1'b1;
      repeat (14) @(posedge hclk);
      rd(`UMH_MSR_PRI_OFS, {24'h0, ~want[3:0], 4'h1 << k});
    end
    want <= 8'hf0;
    repeat (14) @(posedge hclk);
    rd(`UMH_MSR_PRI_OFS, 32'hf0);
    $display("test status done");
    wr(`UMH_IER_PRI_OFS, 32'h8);
    want[0] <= 1'b1;
    repeat (14) @(posedge hclk);
    chk({30'h0, irq4, irq3}, 32'h2);
    ahb(1'b0, `UMH_MSR_PRI_OFS, 32'h0, q);
    repeat (3) @(posedge hclk);
    chk({30'h0, irq4, irq3}, 32'h0);
    wr(`UMH_IER_SEC_OFS, 32'h8);
    want[5] <= 1'b0;
    repeat (14) @(posedge hclk);
    chk({30'h0, irq4, irq3}, 32'h1);
    rd(`UMH_MSR_SEC_OFS, 32'h20);
    wr(`UMH_CFG_OFS, 32'h0a);
    want[0] <= 1'b0;
    repeat (14) @(posedge hclk);
    chk({30'h0, irq4, irq3}, 32'h1);
    wr(`UMH_IER_PRI_OFS, 32'h0);
    ahb(1'b0, `UMH_MSR_PRI_OFS, 32'h0, q);
    want[1] <= 1'b1;
    repeat (14) @(posedge hclk);
    chk({30'h0, irq4, irq3}, 32'h0);
    $display("test interrupt done");
    for (int i = 0; i < 8; i++) begin
      tx_bit_pri <= i[0];
      tx_bit_sec <= i[1];
      want[0] <= i[2];
      repeat (2) @(posedge hclk);
      chk({30'h0, serial_out_pri, serial_out_sec}, {30'h0, i[0], i[1]});
    end
    $display("test transmit done");
    wr(`UMH_CFG_OFS, 32'h09);
    wr(`UMH_MCR_PRI_OFS, 32'h3);
    wr(`UMH_MCR_SEC_OFS, 32'h3);
    repeat (2) @(posedge hclk);
    chk({28'h0, pins}, 32'h0);
    hw_reset <= 1'b1;
    repeat (125) @(posedge hclk);
    chk({28'h0, pins}, 32'hf);
    hw_reset <= 1'b0;
    repeat (10) @(posedge hclk);
    {sec_port_strap_1, sec_port_strap_0} <= 2'h1;
    repeat (2) @(posedge hclk);
    chk({30'h0, sec_addr_sel}, 32'h2);
    ahb(1'b0, `UMH_STAT_OFS, 32'h0, q);
    chk(q & 32'h3, 32'h2);
    rd(`UMH_CFG_OFS, 32'h9);
    rd(`UMH_MCR_PRI_OFS, 32'h0);
    rd(`UMH_IER_SEC_OFS, 32'h0);
    chk({28'h0, pins}, 32'hf);
    // adapter variant routes the port request to its own pin, not the shared lines
    wr(`UMH_IER_PRI_OFS, 32'h8);
    want[0] <= 1'b0;
    repeat (14) @(posedge hclk);
    chk({28'h0, port_irq_pri, port_irq_sec, irq4, irq3}, 32'h8);
    $display("test reset pin done");
    wrap_up;
  end
endmodule // tb_top
